// ---- shared/els_pkg.sv ----
// Shared types and constants for the envelope loop sequencer.
// Assumes a 10 MHz clock; levels are 16-bit unsigned codes.
package els_pkg;

  typedef enum logic [2:0] {
    ST_DELAY, ST_ATTACK, ST_DECAY1, ST_DECAY2, ST_SUSTAIN, ST_REL1, ST_REL2, ST_IDLE
  } els_stage_e;

  typedef enum logic [1:0] {RPT_COUNT, RPT_HELD, RPT_INFINITE} els_repeat_e;
  typedef enum logic [1:0] {DIR_FORWARD, DIR_REVERSE, DIR_PING_PONG} els_dir_e;
  typedef enum logic {TRIG_GATED, TRIG_FREE_RUNNING} els_trig_e;
  typedef enum logic [3:0] {
    CRV_LINEAR, CRV_EXP1, CRV_EXP2, CRV_EXP3, CRV_LOG1, CRV_LOG2, CRV_LOG3,
    CRV_SCURVE1, CRV_SCURVE2
  } els_curve_e;

  localparam int unsigned LEVEL_W        = 16;
  localparam int unsigned FRAC_W         = 8;
  localparam logic [2:0]  STAGE_STEP     = 3'h1;
  localparam logic [7:0]  REPEAT_MIN     = 8'h01;
  localparam logic [7:0]  REPEAT_MAX     = 8'hF0;
  localparam logic [7:0]  CYCLES_RESET   = 8'h00;
  localparam logic [7:0]  FRAC_ZERO      = 8'h00;
  localparam logic [7:0]  FRAC_MAX       = 8'hFF;
  localparam logic [7:0]  FRAC_HALF      = 8'h80;
  localparam logic [31:0] FRAC_STEP      = 32'h0000_0100;
  localparam logic [15:0] SMOOTH_INSTANT = 16'h0000;
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned NS_PER_S       = 1_000_000_000;
  localparam int unsigned SMOOTH_FULL_S  = 32;
  localparam int unsigned SMOOTH_MAX_CODE = 65535;
  // Clock cycles per smoothing time code
  localparam int unsigned SMOOTH_STEP_CYCLES_DEF =
    (SMOOTH_FULL_S * (NS_PER_S / CLK_PERIOD_NS)) / SMOOTH_MAX_CODE;

  typedef struct packed {
    logic                    loop_en;
    logic                    is_amp_env;
    els_repeat_e             repeat_mode;
    logic [7:0]              repeat_count;
    els_dir_e                direction;
    els_trig_e               trig_mode;
    logic [15:0]             smooth_time;
    els_curve_e              curve;
  } els_cfg_s;

  typedef struct packed {
    logic       start_wr;
    logic       end_wr;
    els_stage_e start_val;
    els_stage_e end_val;
  } els_point_wr_s;

  typedef struct packed {
    els_stage_e stage;
    els_stage_e start_sel;
    els_stage_e end_sel;
    logic       looping;
    logic       looped;
    logic       rev;
    logic       smoothing;
    logic       smooth_go;
    logic       stage_start;
    logic       exit_evt;
    logic       r2_zero_seen;
    logic       gate_q;
    logic [7:0] cycles;
  } els_seq_s;

  typedef struct packed {
    logic              active;
    logic              done;
    logic [7:0]        frac;
    logic [31:0]       acc;
    logic [LEVEL_W-1:0] from;
    logic [LEVEL_W-1:0] level;
  } els_smooth_s;

endpackage : els_pkg

// ---- hdl/els_smoother.sv ----
// Shaped level transition used when the loop wraps back to its head stage.
// Assumes the target level is held steady by the caller while active.
`timescale 1ns/1ns
`default_nettype none
module els_smoother
  import els_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = SMOOTH_STEP_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // Control
  input  wire logic               go_i,
  input  wire logic               abort_i,
  input  wire logic [15:0]        time_i,
  input  wire els_curve_e         curve_i,
  // Levels
  input  wire logic [LEVEL_W-1:0] from_i,
  input  wire logic [LEVEL_W-1:0] to_i,
  output logic [LEVEL_W-1:0]      level_o,
  output logic                    active_o,
  output logic                    done_o
);

  els_smooth_s q_ff, nxt_q;
  logic [31:0] span;

  function automatic logic [7:0] mul8(logic [7:0] a, logic [7:0] b);
    logic [15:0] p;
    p = 16'(a) * 16'(b);
    return p[15:8];
  endfunction : mul8

  function automatic logic [7:0] powx(logic [7:0] x, logic [1:0] n);
    logic [7:0] x2;
    x2 = mul8(x, x);
    case (n)
      2'h1: powx = x2;
      2'h2: powx = mul8(x2, x);
      default: powx = mul8(x2, x2);
    endcase
  endfunction : powx

  // Slope curves, same family as ordinary stage slopes
  function automatic logic [7:0] shape(els_curve_e c, logic [7:0] x);
    case (c)
      CRV_EXP1:    shape = powx(x, 2'h1);
      CRV_EXP2:    shape = powx(x, 2'h2);
      CRV_EXP3:    shape = powx(x, 2'h3);
      CRV_LOG1:    shape = ~powx(~x, 2'h1);
      CRV_LOG2:    shape = ~powx(~x, 2'h2);
      CRV_LOG3:    shape = ~powx(~x, 2'h3);
      CRV_SCURVE1: shape = (x < FRAC_HALF) ? 8'({powx(x, 2'h1), 1'b0})
                                          : 8'(~{powx(~x, 2'h1), 1'b0});
      CRV_SCURVE2: shape = (x < FRAC_HALF) ? 8'({powx(x, 2'h2), 2'b00})
                                          : 8'(~{powx(~x, 2'h2), 2'b00});
      default:     shape = x;
    endcase
  endfunction : shape

  function automatic logic [15:0] interp(logic [15:0] a, logic [15:0] b, logic [7:0] f);
    logic signed [16:0] d;
    logic signed [25:0] p;
    d = $signed({1'b0, b}) - $signed({1'b0, a});
    p = d * $signed({1'b0, f});
    return 16'($signed({1'b0, a}) + 17'(p >>> FRAC_W));
  endfunction : interp

  assign span = 32'(time_i) * 32'(STEP_CYCLES);

  always_comb begin
    nxt_q = q_ff;
    nxt_q.done = 1'b0;
    if (abort_i) begin
      nxt_q.active = 1'b0;
    end else if (go_i) begin
      nxt_q.active = 1'b1;
      nxt_q.frac   = FRAC_ZERO;
      nxt_q.acc    = 32'h0;
      nxt_q.from   = from_i;
      nxt_q.level  = from_i;
    end else if (q_ff.active) begin
      nxt_q.acc = q_ff.acc + FRAC_STEP;
      if (nxt_q.acc >= span) begin
        nxt_q.acc  = (span > FRAC_STEP) ? nxt_q.acc - span : 32'h0;
        nxt_q.frac = q_ff.frac + 8'h01;
        if (q_ff.frac == FRAC_MAX - 8'h01) begin
          nxt_q.active = 1'b0;
          nxt_q.done   = 1'b1;
          nxt_q.level  = to_i;
        end else begin
          nxt_q.level = interp(q_ff.from, to_i, shape(curve_i, nxt_q.frac));
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign level_o  = q_ff.level;
  assign active_o = q_ff.active;
  assign done_o   = q_ff.done;

endmodule : els_smoother
`default_nettype wire

// ---- hdl/els_loop_sequencer.sv ----
// Stage sequencer with loop control for one envelope.
// Assumes stage timing logic pulses stage_done_i when a timed stage ends
// and supplies the level of the stage shown on stage_o as target_level_i.
// Notes on behaviour
// - Held repeat keeps looping until the note gate drops, MIDI Note Off too.
// - Held repeat keeps looping while the sustain pedal is down.
// - Infinite repeat on the amplitude envelope never ends by itself.
// - Infinite repeat on a mod envelope ends once amplitude second release hits 0.
// - Forward direction walks the span in ascending order, count and wrap apply.
// - Reverse direction walks the span descending, count and wrap apply.
// - Ping-pong alternates direction, count applies, wrap smoothing is skipped.
// - Wrap transition time is 16 bits, zero instant, 65535 about 32 s.
// - Wrap transition follows linear, three exp, three log or two S-curves.
// - Each forward or reverse wrap glides from present level to head level unless time is zero.
// - Start and end settings push each other so start stays before end.
// - Looping begins exactly when the stage before the end stage completes.
// - Stages after the span are not entered while looping.
// - On loop end in gated trigger mode jump to first release.
// - On loop end in free-running mode continue with remaining stages.
// - First release as end means looping starts only after note-off.
// - Numeric repeat 1 to 240 runs exactly that many cycles then exits the loop.
// - Second release can never be the loop end stage.
// - Each cycle covers start through the stage before end, then returns.
`timescale 1ns/1ns
`default_nettype none
module els_loop_sequencer
  import els_pkg::*;
#(
  parameter int unsigned SMOOTH_STEP_CYCLES = SMOOTH_STEP_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // Performer events
  input  wire logic               note_gate_i,
  input  wire logic               sustain_pedal_i,
  input  wire logic               prog_load_i,
  input  wire logic               amp_r2_zero_i,
  // Stage timing and levels
  input  wire logic               stage_done_i,
  input  wire logic [LEVEL_W-1:0] cur_level_i,
  input  wire logic [LEVEL_W-1:0] target_level_i,
  // Settings
  input  wire els_cfg_s           cfg_i,
  input  wire els_point_wr_s      point_wr_i,
  // Sequencer state
  output var els_stage_e          stage_o,
  output logic                    stage_start_o,
  output logic                    looping_o,
  output logic [7:0]              loop_cycles_o,
  output var els_stage_e          start_sel_o,
  output var els_stage_e          end_sel_o,
  // Wrap transition
  output logic                    smoothing_o,
  output logic [LEVEL_W-1:0]      smooth_level_o
);

  els_seq_s   q_ff, nxt_q;
  logic       note_on;
  logic       smooth_done;
  logic       stage_ends;
  logic       wrap;
  logic       quit;
  els_stage_e head;
  logic [7:0] eff_count;

  function automatic els_stage_e stage_up(els_stage_e s);
    return (s == ST_IDLE) ? ST_IDLE : els_stage_e'(s + STAGE_STEP);
  endfunction : stage_up

  function automatic els_stage_e stage_down(els_stage_e s);
    return (s == ST_DELAY) ? ST_DELAY : els_stage_e'(s - STAGE_STEP);
  endfunction : stage_down

  function automatic logic [7:0] clamp_count(logic [7:0] c);
    if (c < REPEAT_MIN) begin
      return REPEAT_MIN;
    end
    return (c > REPEAT_MAX) ? REPEAT_MAX : c;
  endfunction : clamp_count

  assign note_on   = note_gate_i && !q_ff.gate_q;
  assign eff_count = clamp_count(cfg_i.repeat_count);

  // Loop ends at a wrap point when the repeat setting is satisfied
  always_comb begin
    case (cfg_i.repeat_mode)
      RPT_COUNT:    quit = (q_ff.cycles + 8'h01) >= eff_count;
      RPT_HELD:     quit = !note_gate_i && !sustain_pedal_i;
      RPT_INFINITE: quit = !cfg_i.is_amp_env && q_ff.r2_zero_seen;
      default:      quit = 1'b1;
    endcase
  end

  // Sustain ends on note-off; inside a loop its timer may end it too
  always_comb begin
    if (q_ff.stage == ST_SUSTAIN) begin
      stage_ends = !note_gate_i || (q_ff.looping && stage_done_i);
    end else begin
      stage_ends = stage_done_i && (q_ff.stage != ST_IDLE);
    end
  end

  // Next stage while looping and whether this step is a wrap point
  always_comb begin
    wrap = 1'b0;
    head = stage_up(q_ff.stage);
    case (cfg_i.direction)
      DIR_REVERSE: begin
        if (q_ff.stage == q_ff.start_sel) begin
          wrap = 1'b1;
          head = stage_down(q_ff.end_sel);
        end else begin
          head = stage_down(q_ff.stage);
        end
      end
      DIR_PING_PONG: begin
        if (q_ff.rev) begin
          if (q_ff.stage == q_ff.start_sel) begin
            wrap = 1'b1;
            head = (stage_up(q_ff.start_sel) == q_ff.end_sel) ? q_ff.start_sel
                                                             : stage_up(q_ff.start_sel);
          end else begin
            head = stage_down(q_ff.stage);
          end
        end else begin
          if (stage_up(q_ff.stage) == q_ff.end_sel) begin
            wrap = 1'b1;
            head = (q_ff.stage == q_ff.start_sel) ? q_ff.stage : stage_down(q_ff.stage);
          end
        end
      end
      default: begin
        if (stage_up(q_ff.stage) == q_ff.end_sel) begin
          wrap = 1'b1;
          head = q_ff.start_sel;
        end
      end
    endcase
  end

  always_comb begin
    nxt_q = q_ff;
    nxt_q.stage_start = 1'b0;
    nxt_q.smooth_go   = 1'b0;
    nxt_q.exit_evt    = 1'b0;
    nxt_q.gate_q      = note_gate_i;
    if (prog_load_i) begin
      // New program stops any loop, including infinite ones
      nxt_q.stage        = ST_IDLE;
      nxt_q.looping      = 1'b0;
      nxt_q.looped       = 1'b0;
      nxt_q.smoothing    = 1'b0;
      nxt_q.rev          = 1'b0;
      nxt_q.r2_zero_seen = 1'b0;
      nxt_q.cycles       = CYCLES_RESET;
    end else if (note_on) begin
      nxt_q.stage        = ST_DELAY;
      nxt_q.stage_start  = 1'b1;
      nxt_q.looping      = 1'b0;
      nxt_q.looped       = 1'b0;
      nxt_q.smoothing    = 1'b0;
      nxt_q.rev          = 1'b0;
      nxt_q.r2_zero_seen = 1'b0;
      nxt_q.cycles       = CYCLES_RESET;
    end else if (q_ff.smoothing) begin
      if (smooth_done) begin
        nxt_q.smoothing   = 1'b0;
        nxt_q.stage_start = 1'b1;
      end
    end else if (stage_ends) begin
      if (q_ff.looping) begin
        if (wrap && quit) begin
          nxt_q.looping  = 1'b0;
          nxt_q.rev      = 1'b0;
          nxt_q.exit_evt = 1'b1;
          if (cfg_i.trig_mode == TRIG_GATED) begin
            nxt_q.stage = ST_REL1;
          end else begin
            nxt_q.stage = q_ff.end_sel;
          end
          nxt_q.stage_start = 1'b1;
        end else begin
          nxt_q.stage = head;
          if (wrap) begin
            nxt_q.cycles = q_ff.cycles + 8'h01;
            if (cfg_i.direction == DIR_PING_PONG) begin
              nxt_q.rev = !q_ff.rev;
            end
          end
          if (wrap && cfg_i.direction != DIR_PING_PONG
              && cfg_i.smooth_time != SMOOTH_INSTANT) begin
            nxt_q.smoothing = 1'b1;
            nxt_q.smooth_go = 1'b1;
          end else begin
            nxt_q.stage_start = 1'b1;
          end
        end
      end else if (cfg_i.loop_en && !q_ff.looped
                   && stage_up(q_ff.stage) == q_ff.end_sel) begin
        // Loop is entered at the boundary into the end stage
        nxt_q.looping = 1'b1;
        nxt_q.looped  = 1'b1;
        nxt_q.cycles  = CYCLES_RESET;
        nxt_q.rev     = (cfg_i.direction == DIR_PING_PONG);
        nxt_q.stage   = head;
        if (cfg_i.direction == DIR_FORWARD) begin
          nxt_q.stage = q_ff.start_sel;
        end else if (cfg_i.direction == DIR_REVERSE) begin
          nxt_q.stage = q_ff.stage;
        end
        if (cfg_i.direction != DIR_PING_PONG && cfg_i.smooth_time != SMOOTH_INSTANT) begin
          nxt_q.smoothing = 1'b1;
          nxt_q.smooth_go = 1'b1;
        end else begin
          nxt_q.stage_start = 1'b1;
        end
      end else begin
        nxt_q.stage = (q_ff.stage == ST_REL2) ? ST_IDLE : stage_up(q_ff.stage);
        nxt_q.stage_start = (q_ff.stage != ST_REL2);
      end
    end
    // A level-zero report in the clearing cycle still counts
    if (amp_r2_zero_i) begin
      nxt_q.r2_zero_seen = 1'b1;
    end
    // Loop point settings keep a valid span
    if (point_wr_i.end_wr) begin
      nxt_q.end_sel = point_wr_i.end_val;
      if (point_wr_i.end_val < ST_ATTACK) begin
        nxt_q.end_sel = ST_ATTACK;
      end else if (point_wr_i.end_val > ST_REL1) begin
        nxt_q.end_sel = ST_REL1;
      end
      if (nxt_q.start_sel >= nxt_q.end_sel) begin
        nxt_q.start_sel = stage_down(nxt_q.end_sel);
      end
    end
    if (point_wr_i.start_wr) begin
      nxt_q.start_sel = (point_wr_i.start_val > ST_SUSTAIN) ? ST_SUSTAIN
                                                            : point_wr_i.start_val;
      if (nxt_q.start_sel >= nxt_q.end_sel) begin
        nxt_q.end_sel = stage_up(nxt_q.start_sel);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_ff           <= '0;
      q_ff.stage     <= ST_IDLE;
      q_ff.start_sel <= ST_ATTACK;
      q_ff.end_sel   <= ST_DECAY2;
    end else begin
      q_ff <= nxt_q;
    end
  end

  els_smoother #(
    .STEP_CYCLES (SMOOTH_STEP_CYCLES)
  ) u_smoother (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .go_i     (q_ff.smooth_go),
    .abort_i  (prog_load_i || note_on),
    .time_i   (cfg_i.smooth_time),
    .curve_i  (cfg_i.curve),
    .from_i   (cur_level_i),
    .to_i     (target_level_i),
    .level_o  (smooth_level_o),
    .active_o (),
    .done_o   (smooth_done)
  );

  assign stage_o       = q_ff.stage;
  assign stage_start_o = q_ff.stage_start;
  assign looping_o     = q_ff.looping;
  assign loop_cycles_o = q_ff.cycles;
  assign start_sel_o   = q_ff.start_sel;
  assign end_sel_o     = q_ff.end_sel;
  assign smoothing_o   = q_ff.smoothing;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_span_valid;
    q_ff.start_sel < q_ff.end_sel;
  endproperty
  a_span_valid: assert property (p_span_valid)
    else $error("loop start not before loop end");

  property p_end_legal;
    q_ff.end_sel != ST_REL2 && q_ff.end_sel != ST_DELAY;
  endproperty
  a_end_legal: assert property (p_end_legal)
    else $error("illegal loop end stage");

  property p_inside_span;
    q_ff.looping |-> q_ff.stage >= q_ff.start_sel && q_ff.stage < q_ff.end_sel;
  endproperty
  a_inside_span: assert property (p_inside_span)
    else $error("stage outside loop span while looping");

  property p_cycle_clear;
    $rose(q_ff.looping) |-> q_ff.cycles == CYCLES_RESET && $past(stage_ends);
  endproperty
  a_cycle_clear: assert property (p_cycle_clear)
    else $error("loop began without clear or mid-stage");

  property p_count_limit;
    q_ff.looping && cfg_i.repeat_mode == RPT_COUNT && $stable(cfg_i)
      |-> q_ff.cycles < eff_count;
  endproperty
  a_count_limit: assert property (p_count_limit)
    else $error("loop ran past repeat count");

  property p_gated_exit;
    q_ff.exit_evt && $past(cfg_i.trig_mode) == TRIG_GATED
      |-> q_ff.stage == ST_REL1 && !q_ff.looping && q_ff.stage_start;
  endproperty
  a_gated_exit: assert property (p_gated_exit)
    else $error("gated loop exit did not enter first release");

  property p_free_exit;
    q_ff.exit_evt && $past(cfg_i.trig_mode) == TRIG_FREE_RUNNING
      |-> q_ff.stage == $past(q_ff.end_sel);
  endproperty
  a_free_exit: assert property (p_free_exit)
    else $error("free-running loop exit skipped stages");

  property p_amp_forever;
    q_ff.looping && cfg_i.is_amp_env && cfg_i.repeat_mode == RPT_INFINITE
      && !prog_load_i && !note_on |=> q_ff.looping;
  endproperty
  a_amp_forever: assert property (p_amp_forever)
    else $error("amplitude infinite loop ended");

  property p_held_loop;
    q_ff.looping && cfg_i.repeat_mode == RPT_HELD && (note_gate_i || sustain_pedal_i)
      && !prog_load_i && !note_on |=> q_ff.looping;
  endproperty
  a_held_loop: assert property (p_held_loop)
    else $error("held loop ended while gate or pedal held");

  property p_ping_pong_sharp;
    cfg_i.direction == DIR_PING_PONG && $stable(cfg_i.direction) |=> !q_ff.smooth_go;
  endproperty
  a_ping_pong_sharp: assert property (p_ping_pong_sharp)
    else $error("ping-pong wrap used smoothing");

  property p_smooth_needs_time;
    q_ff.smooth_go |-> $past(cfg_i.smooth_time) != SMOOTH_INSTANT && q_ff.smoothing;
  endproperty
  a_smooth_needs_time: assert property (p_smooth_needs_time)
    else $error("smoothing started with zero time");

  c_loop_exit: cover property (q_ff.exit_evt);
  c_smooth_done: cover property (q_ff.smoothing ##1 !q_ff.smoothing && q_ff.stage_start);
  c_ping_pong_turn: cover property (q_ff.looping && q_ff.rev ##1 !q_ff.rev && q_ff.looping);

endmodule : els_loop_sequencer
`default_nettype wire

// ---- testbench/els_performer.sv ----
// Performer model: key, MIDI note off and sustain pedal seen by the sequencer.
// Assumes the bench drives its controls just after rising clock edges.
`timescale 1ns/1ns
`default_nettype none
module els_performer (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Player actions
  input  wire logic key_down_i,
  input  wire logic midi_off_i,
  input  wire logic pedal_down_i,
  // Lines to the sequencer
  output logic      note_gate_o,
  output logic      sustain_pedal_o
);
  logic off_ff;
  // A note off holds the gate low until the key is struck again
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      off_ff          <= 1'b0;
      note_gate_o     <= 1'b0;
      sustain_pedal_o <= 1'b0;
    end else begin
      off_ff          <= key_down_i & (off_ff | midi_off_i);
      note_gate_o     <= key_down_i & ~midi_off_i & ~off_ff;
      sustain_pedal_o <= pedal_down_i;
    end
  end
endmodule : els_performer
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the loop sequencer: stage walks, repeat modes,
// wrap smoothing and loop point clamping. Smoothing takes one cycle per fraction step, so a code 1 glide runs 255 cycles.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import els_pkg::*;
  logic clk_i = 1'b0, rst_n = 1'b0, sd = 1'b0, prog = 1'b0, r2 = 1'b0;
  logic key = 1'b0, moff = 1'b0, pedal = 1'b0, gate, sus;
  logic [15:0] tgt = 16'h0000, cur = 16'hF00F;
  els_cfg_s cfg = '0;
  els_point_wr_s pw = '0;
  els_stage_e stage_o, start_sel_o, end_sel_o;
  logic stage_start_o, looping_o, smoothing_o;
  logic [7:0] loop_cycles_o;
  logic [15:0] smooth_level_o;
  int err_count = 0, n_checks = 0, cyc = 0;

  always #50 clk_i = ~clk_i;

  els_performer u_perf (.clk_i(clk_i), .rst_n_i(rst_n), .key_down_i(key), .midi_off_i(moff),
    .pedal_down_i(pedal), .note_gate_o(gate), .sustain_pedal_o(sus));

  els_loop_sequencer #(.SMOOTH_STEP_CYCLES(1)) uut (.clk_i(clk_i), .rst_n_i(rst_n),
    .note_gate_i(gate), .sustain_pedal_i(sus), .prog_load_i(prog), .amp_r2_zero_i(r2),
    .stage_done_i(sd), .cur_level_i(cur), .target_level_i(tgt), .cfg_i(cfg),
    .point_wr_i(pw), .stage_o(stage_o), .stage_start_o(stage_start_o),
    .looping_o(looping_o), .loop_cycles_o(loop_cycles_o), .start_sel_o(start_sel_o),
    .end_sel_o(end_sel_o), .smoothing_o(smoothing_o), .smooth_level_o(smooth_level_o));

  function automatic logic [15:0] lvl(input els_stage_e s);
    return {s, 13'h0A5A};
  endfunction : lvl

  always @(posedge clk_i) begin
    tgt <= lvl(stage_o);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  function automatic els_cfg_s mk(input els_repeat_e m, input logic [7:0] n, input els_dir_e d,
                                  input els_trig_e t, input logic amp, input logic [15:0] st,
                                  input els_curve_e c);
    return '{loop_en: 1'b1, is_amp_env: amp, repeat_mode: m, repeat_count: n, direction: d,
             trig_mode: t, smooth_time: st, curve: c};
  endfunction : mk

  task automatic start(input els_cfg_s c);
    @(posedge clk_i);
    cfg  <= c;
    key  <= 1'b0;
    prog <= 1'b1;
    @(posedge clk_i);
    prog <= 1'b0;
    repeat (2) @(posedge clk_i);
    key <= 1'b1;
    repeat (3) @(negedge clk_i);
    chk("stage", stage_o, ST_DELAY);
  endtask : start

  task automatic step;
    @(posedge clk_i);
    sd <= 1'b1;
    @(posedge clk_i);
    sd <= 1'b0;
    @(negedge clk_i);
  endtask : step

  task automatic steps(input els_stage_e e[$]);
    foreach (e[i]) begin
      step();
      chk("stage", stage_o, e[i]);
    end
  endtask : steps

  task automatic pulse_r2;
    @(posedge clk_i);
    r2 <= 1'b1;
    @(posedge clk_i);
    r2 <= 1'b0;
  endtask : pulse_r2

  // Loop point write: end strobe when is_end is set, start strobe otherwise
  task automatic pt(input logic is_end, input els_stage_e v);
    @(posedge clk_i);
    pw <= is_end ? els_point_wr_s'{1'b0, 1'b1, ST_DELAY, v}
                 : els_point_wr_s'{1'b1, 1'b0, v, ST_DELAY};
    @(posedge clk_i);
    pw <= '0;
    @(negedge clk_i);
  endtask : pt

  initial begin
    repeat (12) @(posedge clk_i);
    rst_n <= 1'b1;
    @(negedge clk_i);
    chk("stage", stage_o, ST_IDLE);
    chk("start_sel", start_sel_o, ST_ATTACK);
    chk("end_sel", end_sel_o, ST_DECAY2);
    start(mk(RPT_COUNT, 8'h02, DIR_FORWARD, TRIG_GATED, 1'b1, 16'h0000, CRV_LINEAR));
    steps('{ST_ATTACK, ST_DECAY1, ST_ATTACK});
    chk("looping", looping_o, 16'h0001);
    chk("stage_start", stage_start_o, 16'h0001);
    chk("smoothing", smoothing_o, 16'h0000);
    chk("cycles", loop_cycles_o, 16'h0000);
    steps('{ST_DECAY1, ST_ATTACK});
    chk("cycles", loop_cycles_o, 16'h0001);
    steps('{ST_DECAY1, ST_REL1});
    chk("looping", looping_o, 16'h0000);
    start(mk(RPT_COUNT, 8'h01, DIR_FORWARD, TRIG_FREE_RUNNING, 1'b1, 16'h0000, CRV_LINEAR));
    steps('{ST_ATTACK, ST_DECAY1, ST_ATTACK, ST_DECAY1, ST_DECAY2, ST_SUSTAIN});
    start(mk(RPT_COUNT, 8'h01, DIR_REVERSE, TRIG_GATED, 1'b1, 16'h0000, CRV_LINEAR));
    steps('{ST_ATTACK, ST_DECAY1, ST_DECAY1, ST_ATTACK, ST_REL1});
    start(mk(RPT_COUNT, 8'h01, DIR_PING_PONG, TRIG_GATED, 1'b1, 16'h0001, CRV_LINEAR));
    steps('{ST_ATTACK, ST_DECAY1, ST_ATTACK});
    chk("smoothing", smoothing_o, 16'h0000);
    steps('{ST_REL1});
    start(mk(RPT_HELD, 8'h01, DIR_FORWARD, TRIG_GATED, 1'b1, 16'h0000, CRV_LINEAR));
    steps('{ST_ATTACK, ST_DECAY1, ST_ATTACK});
    @(posedge clk_i);
    pedal <= 1'b1;
    moff  <= 1'b1;
    @(posedge clk_i);
    moff <= 1'b0;
    steps('{ST_DECAY1, ST_ATTACK});
    chk("looping", looping_o, 16'h0001);
    @(posedge clk_i);
    pedal <= 1'b0;
    steps('{ST_DECAY1, ST_REL1});
    start(mk(RPT_INFINITE, 8'h01, DIR_FORWARD, TRIG_GATED, 1'b1, 16'h0000, CRV_LINEAR));
    steps('{ST_ATTACK, ST_DECAY1, ST_ATTACK});
    pulse_r2();
    repeat (3) steps('{ST_DECAY1, ST_ATTACK});
    chk("looping", looping_o, 16'h0001);
    start(mk(RPT_INFINITE, 8'h01, DIR_FORWARD, TRIG_GATED, 1'b0, 16'h0000, CRV_LINEAR));
    steps('{ST_ATTACK, ST_DECAY1, ST_ATTACK});
    pulse_r2();
    steps('{ST_DECAY1, ST_REL1});
    for (int c = 0; c < 9; c++) begin
      start(mk(RPT_COUNT, 8'h02, DIR_FORWARD, TRIG_GATED, 1'b1, 16'h0001, els_curve_e'(c)));
      steps('{ST_ATTACK, ST_DECAY1, ST_ATTACK});
      chk("smoothing", smoothing_o, 16'h0001);
      @(negedge clk_i);
      chk("smooth_from", smooth_level_o, cur);
      for (int i = 0; i < 1000 && smoothing_o !== 1'b0; i++) @(negedge clk_i);
      chk("smooth_level", smooth_level_o, lvl(ST_ATTACK));
      chk("stage_start", stage_start_o, 16'h0001);
    end
    @(posedge clk_i);
    prog <= 1'b1;
    @(posedge clk_i);
    prog <= 1'b0;
    pt(1'b1, ST_ATTACK);
    chk("start_sel", start_sel_o, ST_DELAY);
    pt(1'b0, ST_SUSTAIN);
    chk("end_sel", end_sel_o, ST_REL1);
    pt(1'b1, ST_REL2);
    chk("end_sel", end_sel_o, ST_REL1);
    start(mk(RPT_COUNT, 8'h01, DIR_FORWARD, TRIG_GATED, 1'b1, 16'h0000, CRV_LINEAR));
    steps('{ST_ATTACK, ST_DECAY1, ST_DECAY2, ST_SUSTAIN, ST_SUSTAIN});
    chk("looping", looping_o, 16'h0000);
    @(posedge clk_i);
    key <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk("looping", looping_o, 16'h0001);
    finish_test();
  end
endmodule : tb
`default_nettype wire
